// ===== rtl/esafl_consts.svh
// Constants for the exception stacking, alignment and lazy FP unit
// Assumes inclusion by the design modules, guarded against repeats
`ifndef ESAFL_CONSTS_SVH
`define ESAFL_CONSTS_SVH
`define ESAFL_OFF_CTRL 12'h000
`define ESAFL_OFF_STATUS 12'h004
`define ESAFL_OFF_CTX_ADDR 12'h008
`define ESAFL_BIT_ALIGN_SEL 0
`define ESAFL_BIT_AUTO_FP 1
`define ESAFL_BIT_LAZY_FP 2
`define ESAFL_BIT_LAZY_ACTIVE 0
`define ESAFL_BIT_BUSY 1
`define ESAFL_BIT_LAST_REALIGN 2
`define ESAFL_RST_ALIGN_SEL 1'h1
`define ESAFL_RST_AUTO_FP 1'h1
`define ESAFL_RST_LAZY_FP 1'h1
`define ESAFL_BASIC_SIZE 32'h0000_0020
`define ESAFL_EXT_SIZE 32'h0000_0068
`define ESAFL_FP_SLOT_OFF 32'h0000_0020
`define ESAFL_PSR_ALIGN_BIT 9
`define ESAFL_BASIC_WORDS 5'h08
`define ESAFL_LAST_WORD 5'h19
`define ESAFL_LAST_BASIC 5'h07
`endif

// ===== rtl/esafl_pkg.sv
// Types for the exception stacking, alignment and lazy FP unit
// Assumes a 32-bit address space
package esafl_pkg;
  typedef struct packed {
    logic [31:0] r0;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] r3;
    logic [31:0] r12;
    logic [31:0] lr;
    logic [31:0] ret_addr;
    logic [31:0] psr;
    logic [31:0] sp;
    logic fp_context_active;
    logic handler_mode;
    logic process_stack;
  } esafl_ctx_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } esafl_mem_req_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH = 3'h1,
    ST_LAZY = 3'h3,
    ST_POP = 3'h2,
    ST_POP_FP = 3'h6
  } esafl_state_type;
endpackage : esafl_pkg

// ===== rtl/esafl_entry_calc.sv
// Entry frame pointer and alignment flag
// Assumes a stack pointer that is at least word aligned
`timescale 1ns/100ps
`include "esafl_consts.svh"
module esafl_entry_calc (
  input wire logic [31:0] i_sp,
  input wire logic i_extended,
  input wire logic i_align_select,
  output logic [31:0] o_frame_ptr,
  output logic o_realigned
);
  logic force_align;
  logic [31:0] size;
  logic [31:0] mask;

  always_comb begin
    force_align = i_extended | i_align_select;
    size = i_extended ? `ESAFL_EXT_SIZE : `ESAFL_BASIC_SIZE;
    mask = force_align ? 32'hffff_fff8 : 32'hffff_fffc;
    o_realigned = i_sp[2] & force_align;
    o_frame_ptr = (i_sp - size) & mask;
  end
endmodule : esafl_entry_calc

// ===== rtl/esafl_return_calc.sv
// Stack pointer after popping a frame
// Assumes the popped status word is supplied once read
`timescale 1ns/100ps
`include "esafl_consts.svh"
module esafl_return_calc (
  input wire logic [31:0] i_frame_ptr,
  input wire logic i_extended,
  input wire logic i_align_select,
  input wire logic i_popped_align,
  output logic [31:0] o_sp
);
  logic [31:0] size;

  always_comb begin
    size = i_extended ? `ESAFL_EXT_SIZE : `ESAFL_BASIC_SIZE;
    o_sp = (i_frame_ptr + size) | {29'h0, i_align_select & i_popped_align, 2'h0};
  end
endmodule : esafl_return_calc

// ===== rtl/esafl_top.sv
// Exception entry and return stacking with alignment and lazy FP save
// Assumes one memory port with a request held until acknowledge, APB slave
`timescale 1ns/100ps
`include "esafl_consts.svh"
module esafl_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_entry_req,
  input wire esafl_pkg::esafl_ctx_type i_entry_ctx,
  output logic o_entry_done,
  output logic [31:0] o_entry_sp,
  output logic [31:0] o_exception_return_code,
  output logic o_fp_context_clear,
  input wire logic i_return_req,
  input wire logic [31:0] i_return_sp,
  input wire logic i_return_code_bit4,
  output logic o_return_done,
  output logic o_return_abort,
  output logic [31:0] o_return_sp,
  output logic o_return_fp_context_active,
  output logic o_pop_valid,
  output logic [4:0] o_pop_index,
  output logic [31:0] o_pop_data,
  input wire logic i_fp_instr_req,
  output logic o_fp_instr_go,
  output logic [4:0] o_fp_index,
  input wire logic [31:0] i_fp_word,
  output esafl_pkg::esafl_mem_req_type o_mem,
  input wire logic i_mem_ack,
  input wire logic i_mem_err,
  input wire logic [31:0] i_mem_rdata
);
  import esafl_pkg::*;

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  esafl_state_type state, next_state;
  logic stack_align_select, next_stack_align_select;
  logic auto_fp_preserve_enable, next_auto_fp_preserve_enable;
  logic lazy_fp_preserve_enable, next_lazy_fp_preserve_enable;
  logic lazy_preserve_active, next_lazy_preserve_active;
  logic [31:0] fp_context_address, next_fp_context_address;
  logic last_realign, next_last_realign;
  logic seq_align, next_seq_align;
  logic seq_extended, next_seq_extended;
  logic seq_lazy, next_seq_lazy;
  logic [31:0] base, next_base;
  logic [31:0] ret_start, next_ret_start;
  logic [4:0] idx, next_idx;
  logic [31:0] words [8];
  logic [31:0] next_words [8];
  logic popped_align, next_popped_align;
  logic [31:0] entry_sp, next_entry_sp;
  logic [31:0] ret_code, next_ret_code;
  logic [31:0] return_sp, next_return_sp;
  logic [31:0] pop_data, next_pop_data;
  logic [4:0] pop_index, next_pop_index;
  logic pop_valid, next_pop_valid;
  logic entry_done, next_entry_done;
  logic fp_clear, next_fp_clear;
  logic ret_done, next_ret_done;
  logic ret_abort, next_ret_abort;
  logic [31:0] prdata_q, next_prdata;
  logic slverr_q, next_slverr;
  logic [31:0] calc_frame_ptr;
  logic calc_realigned;
  logic [31:0] calc_return_sp;
  logic entry_ext;
  logic [31:0] rd_value;
  logic rd_hit;
  logic last_word;

  // ----------------------------------------------------------
  // Frame arithmetic
  // ----------------------------------------------------------
  assign entry_ext = i_entry_ctx.fp_context_active & auto_fp_preserve_enable;

  esafl_entry_calc u_entry (
    .i_sp(i_entry_ctx.sp),
    .i_extended(entry_ext),
    .i_align_select(stack_align_select),
    .o_frame_ptr(calc_frame_ptr),
    .o_realigned(calc_realigned)
  );

  esafl_return_calc u_return (
    .i_frame_ptr(ret_start),
    .i_extended(seq_extended),
    .i_align_select(seq_align),
    .i_popped_align(popped_align),
    .o_sp(calc_return_sp)
  );

  // ----------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------
  assign last_word = (idx == `ESAFL_LAST_WORD);
  assign o_fp_index = idx - `ESAFL_BASIC_WORDS;

  always_comb begin
    o_mem.req = (state != ST_IDLE);
    o_mem.we = (state == ST_PUSH) || (state == ST_LAZY);
    o_mem.addr = base + {25'h0, idx, 2'h0};
    o_mem.wdata = (idx < `ESAFL_BASIC_WORDS) ? words[idx[2:0]] : i_fp_word;
  end

  // Lazy save blocks the FP instruction until state is stored
  assign o_fp_instr_go = i_fp_instr_req & ~lazy_preserve_active & (state == ST_IDLE);

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_value = 32'h0;
    unique case (paddr)
      `ESAFL_OFF_CTRL: begin
        rd_value[`ESAFL_BIT_ALIGN_SEL] = stack_align_select;
        rd_value[`ESAFL_BIT_AUTO_FP] = auto_fp_preserve_enable;
        rd_value[`ESAFL_BIT_LAZY_FP] = lazy_fp_preserve_enable;
      end
      `ESAFL_OFF_STATUS: begin
        rd_value[`ESAFL_BIT_LAZY_ACTIVE] = lazy_preserve_active;
        rd_value[`ESAFL_BIT_BUSY] = (state != ST_IDLE);
        rd_value[`ESAFL_BIT_LAST_REALIGN] = last_realign;
      end
      `ESAFL_OFF_CTX_ADDR: rd_value = fp_context_address;
      default: rd_hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slverr_q;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    next_state = state;
    next_stack_align_select = stack_align_select;
    next_auto_fp_preserve_enable = auto_fp_preserve_enable;
    next_lazy_fp_preserve_enable = lazy_fp_preserve_enable;
    next_lazy_preserve_active = lazy_preserve_active;
    next_fp_context_address = fp_context_address;
    next_last_realign = last_realign;
    next_seq_align = seq_align;
    next_seq_extended = seq_extended;
    next_seq_lazy = seq_lazy;
    next_base = base;
    next_ret_start = ret_start;
    next_idx = idx;
    next_words = words;
    next_popped_align = popped_align;
    next_entry_sp = entry_sp;
    next_ret_code = ret_code;
    next_return_sp = return_sp;
    next_pop_data = pop_data;
    next_pop_index = pop_index;
    next_pop_valid = 1'b0;
    next_entry_done = 1'b0;
    next_fp_clear = 1'b0;
    next_ret_done = 1'b0;
    next_ret_abort = 1'b0;
    next_prdata = 32'h0;
    next_slverr = 1'b0;

    if (psel && !penable) begin
      next_prdata = pwrite ? 32'h0 : rd_value;
      next_slverr = ~rd_hit;
    end
    if (psel && penable && pwrite) begin
      if (paddr == `ESAFL_OFF_CTRL) begin
        next_stack_align_select = pwdata[`ESAFL_BIT_ALIGN_SEL];
        next_auto_fp_preserve_enable = pwdata[`ESAFL_BIT_AUTO_FP];
        next_lazy_fp_preserve_enable = pwdata[`ESAFL_BIT_LAZY_FP];
      end else if (paddr == `ESAFL_OFF_CTX_ADDR) begin
        next_fp_context_address = {pwdata[31:3], 3'h0};
      end
    end

    unique case (state)
      ST_IDLE: begin
        if (i_entry_req) begin
          next_seq_align = stack_align_select;
          next_seq_extended = entry_ext;
          next_seq_lazy = entry_ext & lazy_fp_preserve_enable;
          next_base = calc_frame_ptr;
          next_entry_sp = calc_frame_ptr;
          next_last_realign = calc_realigned;
          next_words[0] = i_entry_ctx.r0;
          next_words[1] = i_entry_ctx.r1;
          next_words[2] = i_entry_ctx.r2;
          next_words[3] = i_entry_ctx.r3;
          next_words[4] = i_entry_ctx.r12;
          next_words[5] = i_entry_ctx.lr;
          next_words[6] = i_entry_ctx.ret_addr;
          next_words[7] = i_entry_ctx.psr;
          next_words[7][`ESAFL_PSR_ALIGN_BIT] = calc_realigned;
          // Built from the FP context and mode bits only, never from alignment
          next_ret_code = {27'h7ff_ffff, ~i_entry_ctx.fp_context_active,
            ~i_entry_ctx.handler_mode, i_entry_ctx.process_stack & ~i_entry_ctx.handler_mode,
            2'h1};
          next_idx = 5'h0;
          next_state = ST_PUSH;
        end else if (i_return_req) begin
          next_seq_align = stack_align_select;
          next_seq_extended = ~i_return_code_bit4;
          next_seq_lazy = lazy_preserve_active;
          next_base = i_return_sp;
          next_ret_start = i_return_sp;
          next_idx = 5'h0;
          next_state = ST_POP;
        end else if (i_fp_instr_req && lazy_preserve_active) begin
          next_base = fp_context_address - `ESAFL_FP_SLOT_OFF;
          next_idx = `ESAFL_BASIC_WORDS;
          next_state = ST_LAZY;
        end
      end
      ST_PUSH: begin
        if (i_mem_ack) begin
          if (idx == `ESAFL_LAST_BASIC && (!seq_extended || seq_lazy)) begin
            next_state = ST_IDLE;
            next_entry_done = 1'b1;
            if (seq_lazy) begin
              next_fp_context_address = base + `ESAFL_FP_SLOT_OFF;
              next_lazy_preserve_active = 1'b1;
            end
            next_fp_clear = seq_extended;
          end else if (last_word) begin
            next_state = ST_IDLE;
            next_entry_done = 1'b1;
            next_fp_clear = 1'b1;
          end else begin
            next_idx = idx + 5'h1;
          end
        end
      end
      ST_LAZY: begin
        if (i_mem_ack) begin
          if (last_word) begin
            next_lazy_preserve_active = 1'b0;
            next_state = ST_IDLE;
          end else begin
            next_idx = idx + 5'h1;
          end
        end
      end
      ST_POP, ST_POP_FP: begin
        if (i_mem_err) begin
          // Pointer left as before the exit began
          next_return_sp = ret_start;
          next_ret_abort = 1'b1;
          next_state = ST_IDLE;
        end else if (i_mem_ack) begin
          next_pop_valid = 1'b1;
          next_pop_index = idx;
          next_pop_data = i_mem_rdata;
          if (idx == `ESAFL_LAST_BASIC) begin
            next_popped_align = i_mem_rdata[`ESAFL_PSR_ALIGN_BIT];
          end
          if ((idx == `ESAFL_LAST_BASIC && (!seq_extended || seq_lazy)) || last_word) begin
            next_state = ST_IDLE;
            next_ret_done = 1'b1;
          end else begin
            next_idx = idx + 5'h1;
            next_state = (idx >= `ESAFL_LAST_BASIC) ? ST_POP_FP : ST_POP;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
      stack_align_select <= `ESAFL_RST_ALIGN_SEL;
      auto_fp_preserve_enable <= `ESAFL_RST_AUTO_FP;
      lazy_fp_preserve_enable <= `ESAFL_RST_LAZY_FP;
      lazy_preserve_active <= 1'b0;
      fp_context_address <= 32'h0;
      last_realign <= 1'b0;
      seq_align <= 1'b0;
      seq_extended <= 1'b0;
      seq_lazy <= 1'b0;
      base <= 32'h0;
      ret_start <= 32'h0;
      idx <= 5'h0;
      words <= '{default: 32'h0};
      popped_align <= 1'b0;
      entry_sp <= 32'h0;
      ret_code <= 32'hffff_fff9;
      return_sp <= 32'h0;
      pop_data <= 32'h0;
      pop_index <= 5'h0;
      pop_valid <= 1'b0;
      entry_done <= 1'b0;
      fp_clear <= 1'b0;
      ret_done <= 1'b0;
      ret_abort <= 1'b0;
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else begin
      state <= next_state;
      stack_align_select <= next_stack_align_select;
      auto_fp_preserve_enable <= next_auto_fp_preserve_enable;
      lazy_fp_preserve_enable <= next_lazy_fp_preserve_enable;
      lazy_preserve_active <= next_lazy_preserve_active;
      fp_context_address <= next_fp_context_address;
      last_realign <= next_last_realign;
      seq_align <= next_seq_align;
      seq_extended <= next_seq_extended;
      seq_lazy <= next_seq_lazy;
      base <= next_base;
      ret_start <= next_ret_start;
      idx <= next_idx;
      words <= next_words;
      popped_align <= next_popped_align;
      entry_sp <= next_entry_sp;
      ret_code <= next_ret_code;
      return_sp <= next_return_sp;
      pop_data <= next_pop_data;
      pop_index <= next_pop_index;
      pop_valid <= next_pop_valid;
      entry_done <= next_entry_done;
      fp_clear <= next_fp_clear;
      ret_done <= next_ret_done;
      ret_abort <= next_ret_abort;
      prdata_q <= next_prdata;
      slverr_q <= next_slverr;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign o_entry_done = entry_done;
  assign o_entry_sp = entry_sp;
  assign o_exception_return_code = ret_code;
  assign o_fp_context_clear = fp_clear;
  assign o_return_done = ret_done;
  assign o_return_abort = ret_abort;
  assign o_return_sp = ret_done ? calc_return_sp : return_sp;
  assign o_return_fp_context_active = seq_extended;
  assign o_pop_valid = pop_valid;
  assign o_pop_index = pop_index;
  assign o_pop_data = pop_data;
endmodule : esafl_top

// ===== tb/esafl_props.sv
// Concurrent checks on the exception stacking unit ports
// Assumes binding into esafl_top, one clock domain, sync reset
`timescale 1ns/100ps
module esafl_props (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_entry_req,
  input wire esafl_pkg::esafl_ctx_type i_entry_ctx,
  input wire logic o_entry_done,
  input wire logic [31:0] o_entry_sp,
  input wire logic [31:0] o_exception_return_code,
  input wire logic o_fp_context_clear,
  input wire logic i_return_req,
  input wire logic [31:0] i_return_sp,
  input wire logic o_return_done,
  input wire logic o_return_abort,
  input wire logic [31:0] o_return_sp,
  input wire esafl_pkg::esafl_mem_req_type o_mem,
  input wire logic i_mem_ack,
  input wire logic o_fp_instr_go
);
  import esafl_pkg::*;
  logic seq, next_seq, fpca, next_fpca;
  logic [31:0] esp, next_esp, rsp, next_rsp;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Sequence tracking
  // ----------------------------------------
  always_comb begin
    next_seq = seq;
    next_fpca = fpca;
    next_esp = esp;
    next_rsp = rsp;
    if (o_entry_done || o_return_done || o_return_abort) begin
      next_seq = 1'b0;
    end
    if (!seq && i_entry_req) begin
      next_seq = 1'b1;
      next_fpca = i_entry_ctx.fp_context_active;
      next_esp = i_entry_ctx.sp;
    end else if (!seq && i_return_req) begin
      next_seq = 1'b1;
      next_rsp = i_return_sp;
    end
    if (i_rst) begin
      next_seq = 1'b0;
    end
  end
  always_ff @(posedge i_clock) begin
    seq <= next_seq;
    fpca <= next_fpca;
    esp <= next_esp;
    rsp <= next_rsp;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  entry_bound_a: assert property (!seq && i_entry_req |-> ##[1:400] o_entry_done)
    else $error("entry did not finish in time");
  frame_align_a: assert property (o_entry_done |-> o_entry_sp[1:0] == 2'b00 &&
    !(fpca && o_entry_sp[2]))
    else $error("entry frame pointer misaligned");
  frame_cost_a: assert property (o_entry_done |->
    (esp - o_entry_sp) inside {32'h20, 32'h24, 32'h68, 32'h6c})
    else $error("entry frame size or realign cost wrong");
  code_ones_a: assert property (o_entry_done |->
    o_exception_return_code[31:5] == 27'h7ffffff)
    else $error("return code upper bits altered");
  code_fp_a: assert property (o_entry_done |-> o_exception_return_code[4] == !fpca)
    else $error("return code bit 4 wrong");
  clear_done_a: assert property (o_fp_context_clear |-> o_entry_done && fpca)
    else $error("context clear outside an extended entry");
  mem_hold_a: assert property (o_mem.req && !i_mem_ack |=> $stable(o_mem))
    else $error("memory request changed before acknowledge");
  ret_sp_a: assert property (o_return_done |->
    (o_return_sp - rsp) inside {32'h20, 32'h24, 32'h68, 32'h6c})
    else $error("return stack pointer wrong");
  abort_sp_a: assert property (o_return_abort |-> o_return_sp == rsp)
    else $error("aborted return moved the stack pointer");
  go_clean_a: assert property ($rose(o_fp_instr_go) |-> !o_mem.req)
    else $error("instruction released during save");
  cover property (o_fp_context_clear);
  cover property (o_return_done);
  cover property (o_return_abort);
endmodule : esafl_props

bind esafl_top esafl_props u_esafl_props (.i_clock, .i_rst, .i_entry_req, .i_entry_ctx,
  .o_entry_done, .o_entry_sp, .o_exception_return_code, .o_fp_context_clear, .i_return_req,
  .i_return_sp, .o_return_done, .o_return_abort, .o_return_sp, .o_mem, .i_mem_ack,
  .o_fp_instr_go);

// ===== tb/esafl_mem_model.sv
// Memory system model for the stacking unit
// Assumes requests held until acknowledge, one word per acknowledge
`timescale 1ns/100ps
module esafl_mem_model (
  input wire logic i_clock,
  input wire esafl_pkg::esafl_mem_req_type i_mem,
  input wire logic i_slow,
  input wire logic i_fail,
  output logic o_ack,
  output logic o_err,
  output logic [31:0] o_rdata
);
  import esafl_pkg::*;
  logic [31:0] mem [logic [31:0]];
  int n_wr = 0;
  int wcnt = 0;
  initial begin
    o_ack = 1'b0;
    o_err = 1'b0;
    o_rdata = 32'h0;
  end
  // ----------------------------------------
  // Word access
  // ----------------------------------------
  always @(posedge i_clock) begin
    o_rdata <= ~o_rdata;
    o_err <= 1'b0;
    if (o_ack) begin
      o_ack <= 1'b0;
    end else if (i_mem.req && wcnt < (i_slow ? 2 : 0)) begin
      wcnt <= wcnt + 1;
    end else if (i_mem.req) begin
      wcnt <= 0;
      o_ack <= 1'b1;
      if (i_mem.we) begin
        mem[i_mem.addr] = i_mem.wdata;
        n_wr++;
      end else begin
        o_rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : ~i_mem.addr;
        o_err <= i_fail;
      end
    end
  end
endmodule : esafl_mem_model

// ===== tb/test_exception_stack_align_fp_lazy.sv
// Self-checking bench for the exception stacking unit
// Assumes esafl_top, the memory model and the bound checker
`timescale 1ns/100ps
module test_exception_stack_align_fp_lazy;
  import esafl_pkg::*;
  logic i_clock, i_rst, psel, penable, pwrite, pready, pslverr, i_entry_req, o_entry_done;
  logic o_fp_context_clear, i_return_req, i_return_code_bit4, o_return_done, o_return_abort;
  logic o_return_fp_context_active, o_pop_valid, i_fp_instr_req, o_fp_instr_go;
  logic i_mem_ack, i_mem_err, slow, fail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, o_entry_sp, o_exception_return_code, i_return_sp, o_return_sp;
  logic [31:0] o_pop_data, i_fp_word, i_mem_rdata, rd;
  logic [4:0] o_pop_index, o_fp_index;
  logic er;
  esafl_ctx_type i_entry_ctx;
  esafl_mem_req_type o_mem;
  int n_errors = 0;
  int n_tests = 0;
  assign i_fp_word = {16'hf0f0, 11'h000, o_fp_index};
  esafl_top u_esafl_top (.i_clock, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_entry_req, .i_entry_ctx, .o_entry_done, .o_entry_sp,
    .o_exception_return_code, .o_fp_context_clear, .i_return_req, .i_return_sp,
    .i_return_code_bit4, .o_return_done, .o_return_abort, .o_return_sp,
    .o_return_fp_context_active, .o_pop_valid, .o_pop_index, .o_pop_data, .i_fp_instr_req,
    .o_fp_instr_go, .o_fp_index, .i_fp_word, .o_mem, .i_mem_ack, .i_mem_err, .i_mem_rdata);
  esafl_mem_model u_esafl_mem_model (.i_clock, .i_mem(o_mem), .i_slow(slow), .i_fail(fail),
    .o_ack(i_mem_ack), .o_err(i_mem_err), .o_rdata(i_mem_rdata));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task wrap_up;
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task entry(input logic [31:0] sp, input logic fp, hm, ps, input logic [31:0] fr,
             input int w, input logic b9, input logic [31:0] code);
    int n0;
    n0 = u_esafl_mem_model.n_wr;
    @(posedge i_clock);
    i_entry_ctx <= {32'ha0, 32'ha1, 32'ha2, 32'ha3, 32'hac, 32'hae, 32'h0800_0100,
                    32'h6100_0200, sp, fp, hm, ps};
    i_entry_req <= 1'b1;
    @(posedge i_clock);
    i_entry_req <= 1'b0;
    for (int k = 0; k < 400 && o_entry_done !== 1'b1; k++) @(posedge i_clock);
    chk("entry_done", 32'h1, 32'(o_entry_done));
    chk("fp_clear", 32'(fp), 32'(o_fp_context_clear));
    chk("old_top", sp, o_entry_sp + (o_exception_return_code[4] ? 32'h20 : 32'h68)
      + {29'h0, u_esafl_mem_model.mem[fr + 32'h1c][9], 2'h0});
    chk("frame", fr, o_entry_sp);
    chk("words", w, u_esafl_mem_model.n_wr - n0);
    chk("psr", 32'h6100_0000 | {22'h0, b9, 9'h0}, u_esafl_mem_model.mem[fr + 32'h1c]);
    chk("r0", 32'ha0, u_esafl_mem_model.mem[fr]);
    chk("ret_addr", 32'h0800_0100, u_esafl_mem_model.mem[fr + 32'h18]);
    chk("code", code, o_exception_return_code);
    if (w == 26) chk("fp_status", 32'hf0f0_0010, u_esafl_mem_model.mem[fr + 32'h60]);
    $display("Done entry %h", sp);
  endtask : entry
  task ret(input logic [31:0] sp, input logic b4, b9, f, input logic [31:0] ex, input int pops);
    int n;
    u_esafl_mem_model.mem[sp + 32'h1c] = {22'h0, b9, 9'h0};
    @(posedge i_clock);
    i_return_sp <= sp;
    i_return_code_bit4 <= b4;
    i_return_req <= 1'b1;
    fail <= f;
    @(posedge i_clock);
    i_return_req <= 1'b0;
    n = 0;
    for (int k = 0; k < 400 && o_return_done !== 1'b1 && o_return_abort !== 1'b1; k++) begin
      @(posedge i_clock);
      if (o_pop_valid === 1'b1) begin
        chk("pop_index", n, o_pop_index);
        if (n == 7) chk("pop_psr", {22'h0, b9, 9'h0}, o_pop_data);
        n++;
      end
    end
    chk("ret_end", 32'h1, 32'(o_return_done | o_return_abort));
    chk("ret_sp", ex, o_return_sp);
    chk("abort", 32'(f), 32'(o_return_abort));
    if (!f) chk("pops", pops, n);
    if (!f) chk("ret_fpca", 32'(!b4), 32'(o_return_fp_context_active));
    fail <= 1'b0;
    $display("Done return %h", sp);
  endtask : ret
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_reset", 32'h7, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_rw", 32'h0, rd);
    $display("Done registers");
  endtask : t_regs
  task t_entry;
    apb(1'b1, 12'h000, 32'h1);
    entry(32'h2000_1004, 0, 0, 0, 32'h2000_0fe0, 8, 1, 32'hffff_fff9);
    entry(32'h2000_1000, 0, 1, 0, 32'h2000_0fe0, 8, 0, 32'hffff_fff1);
    apb(1'b1, 12'h000, 32'h0);
    entry(32'h2000_1004, 0, 0, 1, 32'h2000_0fe4, 8, 0, 32'hffff_fffd);
    slow <= 1'b1;
    apb(1'b1, 12'h000, 32'h2);
    entry(32'h2000_1004, 1, 0, 0, 32'h2000_0f98, 26, 1, 32'hffff_ffe9);
    slow <= 1'b0;
    $display("Done entries");
  endtask : t_entry
  task t_lazy;
    int n0;
    apb(1'b1, 12'h000, 32'h6);
    entry(32'h2000_1000, 1, 1, 0, 32'h2000_0f98, 8, 0, 32'hffff_ffe1);
    apb(1'b0, 12'h004, 32'h0);
    chk("lazy_active", 32'h1, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("ctx_addr", 32'h2000_0fb8, rd);
    n0 = u_esafl_mem_model.n_wr;
    @(posedge i_clock);
    i_fp_instr_req <= 1'b1;
    for (int k = 0; k < 400 && o_fp_instr_go !== 1'b1; k++) @(posedge i_clock);
    chk("go", 32'h1, 32'(o_fp_instr_go));
    chk("save_words", 32'd18, u_esafl_mem_model.n_wr - n0);
    chk("s0_slot", 32'hf0f0_0000, u_esafl_mem_model.mem[32'h2000_0fb8]);
    i_fp_instr_req <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk("lazy_clear", 32'h0, rd & 32'h1);
    $display("Done lazy save");
  endtask : t_lazy
  task t_ret;
    apb(1'b1, 12'h000, 32'h1);
    ret(32'h2000_0fe0, 1, 1, 0, 32'h2000_1004, 8);
    apb(1'b1, 12'h000, 32'h0);
    ret(32'h2000_0fe0, 1, 0, 0, 32'h2000_1000, 8);
    apb(1'b1, 12'h000, 32'h1);
    ret(32'h2000_0f98, o_exception_return_code[4], 1, 0, 32'h2000_1004, 26);
    ret(32'h2000_0fe0, 1, 1, 1, 32'h2000_0fe0, 0);
    $display("Done returns");
  endtask : t_ret
  initial begin
    {psel, penable, pwrite, i_entry_req, i_return_req, i_fp_instr_req, slow, fail} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    i_entry_ctx = '0;
    i_return_sp = 32'h0;
    i_return_code_bit4 = 1'b1;
    i_rst = 1'b1;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs;
    t_entry;
    t_lazy;
    t_ret;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    wrap_up;
  end
endmodule : test_exception_stack_align_fp_lazy
